/* File: adc_seq_pkg.sv */
// shared constants for the converter mode sequencer
package adc_seq_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CTRL2 = 8'h08;
   localparam logic [7:0] ADDR_ASSIST = 8'h0C;
   localparam logic [7:0] ADDR_RESULT0 = 8'h20;
   localparam logic [7:0] ADDR_RESULT_LAST = 8'h3C;
   // conv_control_reg0 fields
   localparam int C0_CH_LSB = 0;
   localparam int C0_MODE_LSB = 3;
   localparam int C0_TRIG = 5;
   localparam int C0_START = 6;
   localparam int C0_DIV0 = 7;
   // conv_control_reg1 fields
   localparam int C1_SWEEP_LSB = 0;
   localparam int C1_MODE_EXT = 2;
   localparam int C1_DIV1 = 4;
   localparam int C1_ENABLE = 5;
   localparam int C1_EXT_LSB = 6;
   // conv_control_reg2 fields
   localparam int C2_GROUP_LSB = 1;
   localparam int C2_DIV2 = 4;
   // mode field encodings
   localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
   localparam logic [1:0] MODE_REPEAT = 2'h1;
   localparam logic [1:0] MODE_SINGLE_SWEEP = 2'h2;
   localparam logic [1:0] MODE_REPEAT_SWEEP = 2'h3;
   // extended input field encodings
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_A = 2'h1;
   localparam logic [1:0] EXT_B = 2'h2;
   // timing, in converter base clocks or conversion clocks
   localparam int CONV_CYCLES = 40;
   localparam int CONV_CYCLES_ASSIST = 42;
   localparam int BETWEEN_CYCLES = 1;
   localparam int END_CYCLES = 2;
   localparam int RESULT_W = 10;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_CONV, ST_GAP, ST_END} seq_state_e;
endpackage

/* File: adc_clk_div.sv */
// conversion clock enable divider
`timescale 1ns/1ps
module adc_clk_div #(
   parameter int CNT_W = 4
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // selected division ratio, 1 means every cycle
   input wire logic [CNT_W-1:0] i_ratio,
   // one-cycle enable
   output logic o_tick
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic next_tick;

   always_comb begin
      next_count = count + 1'b1;
      next_tick = 1'b0;
      if (count + 1'b1 >= i_ratio) begin
         next_count = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         count <= '0;
         o_tick <= 1'b0;
      end else begin
         count <= next_count;
         o_tick <= next_tick;
      end
   end
endmodule // adc_clk_div

/* File: adc_mode_sequencer.sv */
// converter mode sequencer with register port and result registers
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - one-shot converts selected input once, then stops
// R2 - software start or falling trigger after start
// R3 - clearing start stops every mode
// R4 - software one-shot/sweep completion clears start bit
// R5 - one-shot/sweep completion raises interrupt request
// R6 - repeating modes never raise interrupt
// R7 - repeat mode converts one input continuously
// R8 - input from channel+group or extended field
// R9 - result goes to register of that pin
// R10 - result registers hold ten bits low
// R11 - sweep set is first 2/4/6/8 inputs
// R12 - group field applies to sweep sets
// R13 - single sweep converts set once, then finishes
// R14 - repeat sweep 0 cycles set until stopped
// R15 - repeat sweep 1 converts all eight, prioritised
// R16 - priority set is first 1-4 inputs
// R17 - priority input interleaves between non-priority inputs
// R18 - software encodes modes with mode bits
// R19 - software keeps converter enabled while running
// R20 - software disables key inputs sharing pins
// R21 - software selects open detection assist
// R22 - trigger levels last two base clocks
// R23 - gap inserted between consecutive conversions
// R24 - sweeps run ascending from input zero
module adc_mode_sequencer #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // external trigger pin, active low edge
   input wire logic i_ext_trigger_pin_n,
   // analog front end: sample value of the addressed input
   input wire logic [adc_seq_pkg::RESULT_W-1:0] i_sample,
   output logic [4:0] o_input_sel,
   output logic o_converting,
   output logic [1:0] o_assist,
   // completion interrupt request, one-cycle pulse
   output logic o_irq
);
   import adc_seq_pkg::*;

   logic [7:0] ctrl0, ctrl1, ctrl2, assist;
   logic [7:0] next_ctrl0, next_ctrl1, next_ctrl2, next_assist;
   logic [RESULT_W-1:0] result_regs [8];
   logic trig_s1, trig_s2, trig_prev;
   seq_state_e state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [2:0] pos, next_pos;
   logic [2:0] prio_idx, next_prio_idx;
   logic prio_turn, next_prio_turn;
   logic [2:0] pin, next_pin;
   logic [15:0] next_rdata;
   logic next_irq;
   logic phi_tick;
   logic [3:0] ratio;
   logic [1:0] mode;
   logic mode_ext, start_bit, sw_trig, fall;
   logic [1:0] ext_sel;
   logic [2:0] set_last, prio_last;
   logic last_pin, done_once;
   logic [CNT_W-1:0] conv_len;
   logic [2:0] rd_idx;

   assign mode = ctrl0[C0_MODE_LSB +: 2];
   assign mode_ext = ctrl1[C1_MODE_EXT];
   assign start_bit = ctrl0[C0_START];
   assign sw_trig = !ctrl0[C0_TRIG];
   assign ext_sel = ctrl1[C1_EXT_LSB +: 2];
   assign fall = trig_prev && !trig_s2; // R2
   assign done_once = (mode == MODE_ONE_SHOT) || (mode == MODE_SINGLE_SWEEP);
   // R11 R16
   assign set_last = {ctrl1[C1_SWEEP_LSB +: 2], 1'b1};
   assign prio_last = {1'b0, ctrl1[C1_SWEEP_LSB +: 2]};
   assign conv_len = (assist[1:0] != 2'h0) ? CNT_W'(CONV_CYCLES_ASSIST) : CNT_W'(CONV_CYCLES);
   assign rd_idx = i_addr[4:2];

   // divide selection: 1,2,3,4,6,12 from the three divider bits
   always_comb begin
      case ({ctrl2[C2_DIV2], ctrl1[C1_DIV1], ctrl0[C0_DIV0]})
         3'h0: ratio = 4'h4;
         3'h1: ratio = 4'h2;
         3'h2: ratio = 4'h1;
         3'h4: ratio = 4'h3;
         3'h5: ratio = 4'h6;
         3'h6: ratio = 4'hC;
         default: ratio = 4'h1;
      endcase
   end

   adc_clk_div #(.CNT_W(4)) u_div (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ratio(ratio),
      .o_tick(phi_tick)
   );

   // last pin of the current pass, per mode
   always_comb begin
      case (mode)
         MODE_SINGLE_SWEEP: last_pin = (pin == set_last);
         MODE_REPEAT_SWEEP: last_pin = mode_ext ? 1'b0 : (pin == set_last);
         default: last_pin = 1'b1;
      endcase
   end

   // sequencer and registers
   always_comb begin
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      next_assist = assist;
      next_state = state;
      next_cnt = cnt;
      next_pos = pos;
      next_prio_idx = prio_idx;
      next_prio_turn = prio_turn;
      next_pin = pin;
      next_irq = 1'b0;
      next_rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            ADDR_CTRL0: next_rdata = {8'h00, ctrl0};
            ADDR_CTRL1: next_rdata = {8'h00, ctrl1};
            ADDR_CTRL2: next_rdata = {8'h00, ctrl2};
            ADDR_ASSIST: next_rdata = {8'h00, assist};
            default: begin
               if (i_addr >= ADDR_RESULT0 && i_addr <= ADDR_RESULT_LAST && i_addr[1:0] == 2'h0) begin
                  next_rdata = {6'h00, result_regs[rd_idx]}; // R10
               end
            end
         endcase
      end
      if (i_wr) begin
         case (i_addr)
            ADDR_CTRL0: next_ctrl0 = i_wdata;
            ADDR_CTRL1: next_ctrl1 = i_wdata;
            ADDR_CTRL2: next_ctrl2 = i_wdata;
            ADDR_ASSIST: next_assist = {6'h00, i_wdata[1:0]};
            default: ;
         endcase
      end
      case (state)
         ST_IDLE: begin
            if (start_bit) begin
               // R2 R24
               next_state = sw_trig ? ST_CONV : ST_ARMED;
               next_cnt = '0;
               next_pos = 3'h0;
               next_prio_idx = 3'h0;
               next_prio_turn = 1'b1;
               next_pin = 3'h0;
               if (mode == MODE_ONE_SHOT || mode == MODE_REPEAT) begin
                  next_pin = ctrl0[C0_CH_LSB +: 3]; // R8
                  if (ext_sel == EXT_A) next_pin = 3'h0;
                  if (ext_sel == EXT_B) next_pin = 3'h1;
               end
            end
         end
         ST_ARMED: begin
            if (fall) next_state = ST_CONV; // R2
         end
         ST_CONV: begin
            if (phi_tick) begin
               next_cnt = cnt + 1'b1;
               if (cnt + 1'b1 == conv_len) begin
                  next_cnt = '0;
                  next_state = (done_once && last_pin) ? ST_END : ST_GAP; // R1 R7 R13
               end
            end
         end
         ST_GAP: begin
            // R23
            if (phi_tick) begin
               next_state = ST_CONV;
               if (mode == MODE_REPEAT_SWEEP && mode_ext) begin
                  // R15 R17
                  if (prio_turn) begin
                     next_prio_turn = 1'b0;
                     next_pos = (pos == 3'h7 || pos < prio_last) ? prio_last + 3'h1 : pos + 3'h1;
                     if (prio_last == 3'h7) next_pos = 3'h0;
                     next_pin = next_pos;
                     if (prio_last == 3'h3 && pos == 3'h7) next_pin = 3'h4;
                  end else begin
                     next_prio_turn = 1'b1;
                     next_prio_idx = (prio_idx == prio_last) ? 3'h0 : prio_idx + 3'h1;
                     next_pin = next_prio_idx;
                  end
               end else if (mode != MODE_ONE_SHOT && mode != MODE_REPEAT) begin
                  next_pin = last_pin ? 3'h0 : pin + 3'h1; // R14 R24
               end
            end
         end
         ST_END: begin
            if (phi_tick) begin
               next_cnt = cnt + 1'b1;
               if (cnt + 1'b1 == CNT_W'(END_CYCLES)) begin
                  // a re-armed trigger run must start its conversion count from zero
                  next_cnt = '0;
                  next_state = ST_IDLE;
                  next_irq = 1'b1; // R5
                  if (sw_trig) next_ctrl0[C0_START] = 1'b0; // R4
                  else next_state = ST_ARMED;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // R3
      if (!next_ctrl0[C0_START] && state != ST_END) begin
         next_state = ST_IDLE;
         next_irq = 1'b0;
      end
      if (!done_once) next_irq = 1'b0; // R6
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl0 <= RESET_BYTE;
         ctrl1 <= RESET_BYTE;
         ctrl2 <= RESET_BYTE;
         assist <= RESET_BYTE;
         state <= ST_IDLE;
         cnt <= '0;
         pos <= 3'h0;
         prio_idx <= 3'h0;
         prio_turn <= 1'b1;
         pin <= 3'h0;
         o_rdata <= 16'h0000;
         o_irq <= 1'b0;
         o_input_sel <= 5'h00;
         o_converting <= 1'b0;
         o_assist <= 2'h0;
         trig_s1 <= 1'b1;
         trig_s2 <= 1'b1;
         trig_prev <= 1'b1;
      end else begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
         assist <= next_assist;
         state <= next_state;
         cnt <= next_cnt;
         pos <= next_pos;
         prio_idx <= next_prio_idx;
         prio_turn <= next_prio_turn;
         pin <= next_pin;
         o_rdata <= next_rdata;
         o_irq <= next_irq;
         // bit4 extended, bit3 group alt, low bits pin
         o_input_sel <= {(ext_sel != EXT_NONE) && !mode[1], ctrl2[C2_GROUP_LSB], next_pin}; // R8 R12
         o_converting <= (next_state == ST_CONV);
         o_assist <= assist[1:0];
         trig_s1 <= i_ext_trigger_pin_n;
         trig_s2 <= trig_s1;
         trig_prev <= trig_s2;
      end
   end

   // results land in the register of the converted pin; sampled at the end of conversion
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         for (int i = 0; i < 8; i++) result_regs[i] <= '0;
      end else if (state == ST_CONV && phi_tick && cnt + 1'b1 == conv_len && next_ctrl0[C0_START]) begin
         result_regs[pin] <= i_sample; // R9
      end
   end

   AST_IRQ_ONLY_ONCE_MODES: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
      o_irq |-> $past(done_once))
      else $error("irq in repeating mode");
   AST_START_CLEARS: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
      (!start_bit && !$past(i_wr)) |=> !o_converting)
      else $error("converting with start clear");
   AST_SW_AUTOCLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
      (o_irq && $past(sw_trig)) |-> !start_bit)
      else $error("start bit not cleared");
   sequence s_conv_done;
      state == ST_CONV && phi_tick && cnt + 1'b1 == conv_len && !i_wr;
   endsequence
   AST_GAP_AFTER: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R23
      (s_conv_done and (!done_once)) |=> state == ST_GAP)
      else $error("no gap between conversions");
   AST_ONESHOT_END: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
      (s_conv_done and (mode == MODE_ONE_SHOT && start_bit)) |=> state == ST_END)
      else $error("one-shot did not finish");
   AST_ARMED_WAITS: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
      (state == ST_ARMED && !fall && !i_wr) |=> state == ST_ARMED)
      else $error("started without trigger edge");
   AST_SWEEP_WRAP: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
      (state == ST_GAP && phi_tick && mode == MODE_REPEAT_SWEEP && !mode_ext && pin == set_last && !i_wr)
      |=> pin == 3'h0)
      else $error("sweep did not wrap to zero");
   AST_PRIO_INTERLEAVE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
      (state == ST_GAP && phi_tick && mode == MODE_REPEAT_SWEEP && mode_ext && !prio_turn && !i_wr)
      |=> pin <= prio_last)
      else $error("priority input skipped");
endmodule // adc_mode_sequencer

/* File: adc_far_end.sv */
// far-side model: analog inputs and external trigger source
`timescale 1ns/1ps
module adc_far_end (
   // clock
   input wire logic i_ref_clk,
   // trigger request from the bench
   input wire logic i_fire,
   // input selected by the sequencer
   input wire logic [4:0] i_input_sel,
   // toward the sequencer
   output logic [9:0] o_sample,
   output logic o_trig_n
);
   logic [2:0] low_cnt = 3'h0;
   // distinct code per pin so a misrouted result shows up
   // inputs are pure analog sources, no key-input interrupt shares them
   assign o_sample = {5'h15, i_input_sel};
   // low level held four clocks, above the two-clock minimum
   always @(posedge i_ref_clk) begin
      if (i_fire && low_cnt == 3'h0) low_cnt <= 3'h4;
      else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
   end
   assign o_trig_n = (low_cnt == 3'h0);
endmodule // adc_far_end

/* File: adc_mode_sequencer_test.sv */
// self-checking bench for the converter mode sequencer
`timescale 1ns/1ps
module adc_mode_sequencer_test;
   import adc_seq_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fire = 1'b0;
   logic [15:0] rdata;
   logic trig_n;
   logic [9:0] sample;
   logic [4:0] sel;
   logic conv;
   logic [1:0] assist;
   logic irq;
   logic prev = 1'b0;
   int mismatches = 0;
   int samples_checked = 0;
   int irqs = 0;
   int run_len = 0;
   logic [4:0] seen[$];
   logic [15:0] v;

   adc_mode_sequencer #(.CNT_W(6)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_trigger_pin_n(trig_n), .i_sample(sample),
      .o_input_sel(sel), .o_converting(conv), .o_assist(assist), .o_irq(irq));
   adc_far_end far_u (.i_ref_clk(clk), .i_fire(fire), .i_input_sel(sel), .o_sample(sample), .o_trig_n(trig_n));

   initial begin
      forever #20 clk = ~clk;
   end

   // record each converted pin and each completion pulse
   always @(negedge clk) begin
      if (conv === 1'b1 && prev !== 1'b1) begin
         seen.push_back(sel);
         run_len = 0;
      end
      if (conv === 1'b1) run_len++;
      prev = conv;
      if (irq === 1'b1) irqs++;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic res(input logic [2:0] i, input logic [4:0] s);
      rd_reg(ADDR_RESULT0 + {3'h0, i, 2'h0}, v);
      chk(v, {6'h00, 5'h15, s});
   endtask

   // divider ratio 1 keeps conversions short; enable is set before start
   task automatic setup(input logic [1:0] grp, input logic [1:0] ext, input logic me, input logic [1:0] sw);
      wr_reg(ADDR_CTRL2, {5'h00, grp, 1'b0});
      wr_reg(ADDR_CTRL1, {ext, 2'h3, 1'b0, me, sw});
   endtask

   task automatic go(input logic [1:0] md, input logic tr, input logic [2:0] ch);
      seen.delete();
      irqs = 0;
      wr_reg(ADDR_CTRL0, {2'h1, tr, md, ch});
   endtask

   task automatic wait_irq(input int n);
      int k;
      k = 0;
      while (irqs == 0 && k < n) begin
         @(posedge clk);
         k++;
      end
      if (irqs == 0) begin
         mismatches++;
         $display("ERROR %0t no completion", $time);
         close_out();
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic chk_seq(input logic [4:0] e[$]);
      chk({15'h0, seen.size() >= e.size()}, 16'h0001);
      foreach (e[i]) if (i < seen.size()) chk({11'h0, seen[i]}, {11'h0, e[i]});
   endtask

   // run a repeating mode, stop it by clearing start, expect no interrupt
   task automatic t_rep(input logic [1:0] md, input int n, input logic [4:0] e[$]);
      go(md, 1'b0, 3'h2);
      repeat (n) @(posedge clk);
      wr_reg(ADDR_CTRL0, {3'h0, md, 3'h0});
      repeat (3) @(posedge clk);
      chk({15'h0, conv}, 16'h0000);
      chk(irqs[15:0], 16'h0000);
      chk_seq(e);
   endtask

   task automatic t_oneshot();
      setup(2'h0, EXT_NONE, 1'b0, 2'h0);
      go(MODE_ONE_SHOT, 1'b0, 3'h3);
      wait_irq(300);
      chk(irqs[15:0], 16'h0001);
      chk(run_len[15:0], 16'(CONV_CYCLES));
      chk_seq('{5'h03});
      res(3'h3, 5'h03);
      rd_reg(ADDR_CTRL0, v);
      chk({15'h0, v[C0_START]}, 16'h0000);
      setup(2'h0, EXT_B, 1'b0, 2'h0);
      go(MODE_ONE_SHOT, 1'b0, 3'h0);
      wait_irq(300);
      res(3'h1, 5'h11);
      setup(2'h1, EXT_NONE, 1'b0, 2'h0);
      wr_reg(ADDR_ASSIST, 8'h01);
      go(MODE_ONE_SHOT, 1'b0, 3'h5);
      wait_irq(300);
      res(3'h5, 5'h0D);
      chk(run_len[15:0], 16'(CONV_CYCLES_ASSIST));
      wr_reg(ADDR_ASSIST, 8'h00);
   endtask

   task automatic t_sweep();
      setup(2'h0, EXT_NONE, 1'b0, 2'h1);
      go(MODE_SINGLE_SWEEP, 1'b0, 3'h0);
      wait_irq(600);
      repeat (60) @(posedge clk);
      chk(irqs[15:0], 16'h0001);
      chk_seq('{5'h00, 5'h01, 5'h02, 5'h03});
      chk({11'h0, 5'(seen.size())}, 16'h0004);
      res(3'h2, 5'h02);
   endtask

   task automatic t_ext();
      setup(2'h0, EXT_NONE, 1'b0, 2'h0);
      go(MODE_ONE_SHOT, 1'b1, 3'h4);
      repeat (30) @(posedge clk);
      chk({11'h0, 5'(seen.size())}, 16'h0000);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wait_irq(300);
      res(3'h4, 5'h04);
      rd_reg(ADDR_CTRL0, v);
      chk({15'h0, v[C0_START]}, 16'h0001);
      // the re-armed trigger path must run a second full-length conversion
      irqs = 0;
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wait_irq(300);
      chk(run_len[15:0], 16'(CONV_CYCLES));
      wr_reg(ADDR_CTRL0, 8'h00);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h10, v);
      chk(v, 16'h0000);
      wr_reg(ADDR_ASSIST, 8'h02);
      // the output copy lags the register by one clock
      repeat (2) @(negedge clk);
      chk({14'h0, assist}, 16'h0002);
      wr_reg(ADDR_ASSIST, 8'h00);
      t_oneshot();
      t_sweep();
      setup(2'h0, EXT_NONE, 1'b0, 2'h0);
      t_rep(MODE_REPEAT, 400, '{5'h02, 5'h02, 5'h02, 5'h02, 5'h02});
      t_rep(MODE_REPEAT_SWEEP, 200, '{5'h00, 5'h01, 5'h00, 5'h01});
      setup(2'h1, EXT_NONE, 1'b1, 2'h0);
      t_rep(MODE_REPEAT_SWEEP, 300, '{5'h08, 5'h09, 5'h08, 5'h0A, 5'h08, 5'h0B});
      t_ext();
      close_out();
   end
endmodule // adc_mode_sequencer_test
